// [hw/hsie_pkg.sv]
// Package with register map, field layout, reset values and carrier types of the serial IRQ enable block.
package hsie_pkg;

  // Register bus widths.
  localparam int AW = 4;
  localparam int DW = 8;

  // Register offsets.
  localparam logic [AW-1:0] OFS_CTL   = 4'h0;
  localparam logic [AW-1:0] OFS_MODE  = 4'h1;
  localparam logic [AW-1:0] OFS_STAT  = 4'h2;
  localparam logic [AW-1:0] OFS_IST   = 4'h3;
  localparam logic [AW-1:0] OFS_IMASK = 4'h4;

  // Field positions in host_serial_irq_control_1.
  localparam int BIT_CH3_IRQ10 = 6;
  localparam int BIT_CH3_IRQ9  = 5;
  localparam int BIT_CH3_IRQ6  = 4;
  localparam int BIT_CH2_IRQ11 = 3;
  localparam logic [DW-1:0] CTL_CH3_MASK = 8'h70;
  localparam logic [DW-1:0] CTL_CH2_MASK = 8'h08;
  localparam logic [DW-1:0] CTL_IMPL     = 8'h78;
  localparam logic [DW-1:0] CTL_RST      = 8'h00;

  // Mode register field and status register fields.
  localparam int MODE_DIR_BIT = 0;
  localparam int STAT_OBF3    = 4;
  localparam int STAT_CH2_OUTPUT_FULL_FLAG    = 5;
  localparam int STAT_LRST    = 6;

  // Interrupt status layout: bits 3..0 request raised, bit 4 enable auto-cleared.
  localparam int IST_W      = 5;
  localparam int EV_AUTOCLR = 4;
  localparam logic [IST_W-1:0] IST_RST   = 5'h00;
  localparam logic [IST_W-1:0] IMASK_RST = 5'h00;

  // Register bus request carrier.
  typedef struct packed {
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic          wr;
    logic          rd;
  } hsie_bus_t;

  // Whole state of the block.
  typedef struct packed {
    logic [DW-1:0]    ctl;
    logic [DW-1:0]    arm;
    logic             dir;
    logic             obf3;
    logic             ch2_output_full_flag;
    logic [3:0]       req;
    logic [IST_W-1:0] ist;
    logic [IST_W-1:0] imask;
    logic [DW-1:0]    rdata;
    logic [2:0]       lclk_s;
    logic [1:0]       lrst_s;
    logic [1:0]       lsrst_s;
    logic             lsrst;
  } hsie_state_t;

  localparam hsie_state_t ST_RST = '0;

endpackage : hsie_pkg

// [hw/hsie_core.sv]
// Enable logic for host serial IRQ requests that follow the channel 2 and channel 3 output full flags.
//
// Operation
// - Bit 6 enables host IRQ10 from channel 3 output full when not direct.
// - In direct mode bit 6 set raises host IRQ10 by itself.
// - Bit 6 clears on write 0, LPC reset, or channel 3 flag clear when not direct.
// - Writing 1 to bit 6 works only after it was read as 0.
// - Bit 5 enables host IRQ9 from channel 3 output full when not direct.
// - In direct mode bit 5 set raises host IRQ9 by itself.
// - Bit 5 clears on write 0, LPC reset, or channel 3 flag clear when not direct.
// - Writing 1 to bit 5 works only after it was read as 0.
// - Bit 4 enables host IRQ6 from channel 3 output full when not direct.
// - In direct mode bit 4 set raises host IRQ6 by itself.
// - Bit 4 clears on write 0, LPC reset, or channel 3 flag clear when not direct.
// - Writing 1 to bit 4 works only after it was read as 0.
// - Bit 3 enables host IRQ11 from channel 2 output full when not direct.
// - In direct mode bit 3 set raises host IRQ11 by itself.
// - Bit 3 clears on write 0, LPC reset, or channel 2 flag clear when not direct.
// - Writing 1 to bit 3 works only after it was read as 0.
//
// Chosen here: the address map and strobed register access.
`timescale 1ns/100ps

module hsie_core (
  input  wire logic              i_mclk,
  input  wire logic              i_nrst,
  input  wire hsie_pkg::hsie_bus_t i_bus,
  output logic [hsie_pkg::DW-1:0] o_rdata,
  input  wire logic              i_ch3_obf,
  input  wire logic              i_ch2_obf,
  input  wire logic              i_lclk,
  input  wire logic              i_lreset_n,
  input  wire logic              i_lsrst,
  output logic                   o_irq10_req,
  output logic                   o_irq9_req,
  output logic                   o_irq6_req,
  output logic                   o_irq11_req,
  output logic                   o_irq
);

  hsie_pkg::hsie_state_t st_r;
  hsie_pkg::hsie_state_t st_nxt;

  logic                   lclk_rise;
  logic                   lpc_rst;
  logic                   wr_ctl;
  logic                   rd_ctl;
  logic [hsie_pkg::DW-1:0] fall;
  logic [hsie_pkg::DW-1:0] hw_clr;
  logic [hsie_pkg::DW-1:0] wr_zero;
  logic [hsie_pkg::DW-1:0] wr_set;
  logic [hsie_pkg::DW-1:0] reqv;
  logic [hsie_pkg::IST_W-1:0] ev;
  logic [hsie_pkg::IST_W-1:0] w1c;

  // Spreads the two channel flags over the enable bits that follow them.
  function automatic logic [hsie_pkg::DW-1:0] flag_mask(input logic f3, input logic f2);
    flag_mask = (f3 ? hsie_pkg::CTL_CH3_MASK : 8'h00) | (f2 ? hsie_pkg::CTL_CH2_MASK : 8'h00);
  endfunction : flag_mask

  // Next-state logic of the whole block.
  always_comb begin
    st_nxt = st_r;
    // Link-side inputs pass two flops before use; the link clock edge is found on the synchronised copy.
    st_nxt.lclk_s  = {st_r.lclk_s[1:0], i_lclk};
    st_nxt.lrst_s  = {st_r.lrst_s[0], i_lreset_n};
    st_nxt.lsrst_s = {st_r.lsrst_s[0], i_lsrst};
    lclk_rise = st_r.lclk_s[1] && !st_r.lclk_s[2];
    if (lclk_rise) begin
      st_nxt.lsrst = st_r.lsrst_s[1];
    end
    lpc_rst = !st_r.lrst_s[1] || st_r.lsrst;

    // Flag history for edge detection.
    st_nxt.obf3 = i_ch3_obf;
    st_nxt.ch2_output_full_flag = i_ch2_obf;
    fall   = flag_mask(st_r.obf3 && !i_ch3_obf, st_r.ch2_output_full_flag && !i_ch2_obf);
    hw_clr = st_r.dir ? 8'h00 : fall;

    // Slave writes: a zero clears, a one sets only where the bit was read as 0.
    wr_ctl  = i_bus.wr && (i_bus.addr == hsie_pkg::OFS_CTL);
    rd_ctl  = i_bus.rd && (i_bus.addr == hsie_pkg::OFS_CTL);
    wr_zero = wr_ctl ? (~i_bus.wdata & hsie_pkg::CTL_IMPL) : 8'h00;
    wr_set  = wr_ctl ? (i_bus.wdata & st_r.arm & hsie_pkg::CTL_IMPL) : 8'h00;

    // A software set in the cycle of a flag clear wins.
    st_nxt.ctl = ((st_r.ctl & ~wr_zero & ~hw_clr) | wr_set) & hsie_pkg::CTL_IMPL;

    // Reading a bit as 0 arms it; any write to the register disarms all bits.
    if (rd_ctl) begin
      st_nxt.arm = st_r.arm | (~st_r.ctl & hsie_pkg::CTL_IMPL);
    end
    if (wr_ctl) begin
      st_nxt.arm = 8'h00;
    end

    // LPC hardware or software reset clears the enables and overrides a write.
    if (lpc_rst) begin
      st_nxt.ctl = hsie_pkg::CTL_RST;
      st_nxt.arm = 8'h00;
    end

    // Direct request mode selector.
    if (i_bus.wr && (i_bus.addr == hsie_pkg::OFS_MODE)) begin
      st_nxt.dir = i_bus.wdata[hsie_pkg::MODE_DIR_BIT];
    end

    // Host request levels: the enable alone in direct mode, else the enable and its flag.
    reqv = st_nxt.dir ? st_nxt.ctl : (st_nxt.ctl & flag_mask(st_nxt.obf3, st_nxt.ch2_output_full_flag));
    st_nxt.req = reqv[hsie_pkg::BIT_CH3_IRQ10:hsie_pkg::BIT_CH2_IRQ11];

    // Sticky events; a new event beats a write-one clear in the same cycle.
    ev = {(|(st_r.ctl & hw_clr & ~wr_set)) && !lpc_rst, st_nxt.req & ~st_r.req};
    w1c = (i_bus.wr && (i_bus.addr == hsie_pkg::OFS_IST)) ? i_bus.wdata[hsie_pkg::IST_W-1:0] : 5'h00;
    st_nxt.ist = (st_r.ist & ~w1c) | ev;
    if (i_bus.wr && (i_bus.addr == hsie_pkg::OFS_IMASK)) begin
      st_nxt.imask = i_bus.wdata[hsie_pkg::IST_W-1:0];
    end

    // Read data stands one cycle after the strobe; unmapped offsets and idle cycles read zero.
    st_nxt.rdata = 8'h00;
    if (i_bus.rd) begin
      case (i_bus.addr)
        hsie_pkg::OFS_CTL:   st_nxt.rdata = st_r.ctl;
        hsie_pkg::OFS_MODE:  st_nxt.rdata = {7'h00, st_r.dir};
        hsie_pkg::OFS_STAT:  st_nxt.rdata = {1'b0, lpc_rst, st_r.ch2_output_full_flag, st_r.obf3, st_r.req};
        hsie_pkg::OFS_IST:   st_nxt.rdata = {3'h0, st_r.ist};
        hsie_pkg::OFS_IMASK: st_nxt.rdata = {3'h0, st_r.imask};
        default:             st_nxt.rdata = 8'h00;
      endcase
    end
  end

  // State register with synchronous active-low reset.
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      st_r <= hsie_pkg::ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs come from the state register; o_irq is the OR of the unmasked status bits.
  assign o_rdata     = st_r.rdata;
  assign o_irq10_req = st_r.req[3];
  assign o_irq9_req  = st_r.req[2];
  assign o_irq6_req  = st_r.req[1];
  assign o_irq11_req = st_r.req[0];
  assign o_irq       = |(st_r.ist & st_r.imask);

  // Checks on the enable and request behaviour.
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_nrst);

  property p_irq10_flag;
    !st_r.dir && st_r.ctl[6] && st_r.obf3 |-> o_irq10_req;
  endproperty
  a_irq10_flag: assert property (p_irq10_flag) else $error("IRQ10 request missing with enable and flag.");

  property p_irq10_gate;
    !st_r.dir && !st_r.obf3 |-> !o_irq10_req;
  endproperty
  a_irq10_gate: assert property (p_irq10_gate) else $error("IRQ10 request without flag in flag mode.");

  property p_direct;
    st_r.dir |-> (st_r.req == st_r.ctl[6:3]);
  endproperty
  a_direct: assert property (p_direct) else $error("Direct mode requests differ from enables.");

  property p_irq9_flag;
    !st_r.dir && st_r.obf3 |-> (o_irq9_req == st_r.ctl[5]) && (o_irq6_req == st_r.ctl[4]);
  endproperty
  a_irq9_flag: assert property (p_irq9_flag) else $error("Channel 3 IRQ9 or IRQ6 request wrong.");

  property p_irq11_flag;
    !st_r.dir |-> (o_irq11_req == (st_r.ctl[3] && st_r.ch2_output_full_flag));
  endproperty
  a_irq11_flag: assert property (p_irq11_flag) else $error("Channel 2 IRQ11 request wrong.");

  property p_autoclr;
    !st_r.dir && st_r.obf3 && !i_ch3_obf && !wr_ctl |=> !st_r.ctl[6] && !st_r.ctl[5] && !st_r.ctl[4];
  endproperty
  a_autoclr: assert property (p_autoclr) else $error("Channel 3 enables kept after flag clear.");

  property p_autoclr2;
    !st_r.dir && st_r.ch2_output_full_flag && !i_ch2_obf && !wr_ctl |=> !st_r.ctl[3];
  endproperty
  a_autoclr2: assert property (p_autoclr2) else $error("Channel 2 enable kept after flag clear.");

  property p_write0;
    wr_ctl && !i_bus.wdata[5] |=> !st_r.ctl[5];
  endproperty
  a_write0: assert property (p_write0) else $error("IRQ9 enable survived a write of zero.");

  property p_lpc_rst;
    lpc_rst |=> (st_r.ctl == hsie_pkg::CTL_RST);
  endproperty
  a_lpc_rst: assert property (p_lpc_rst) else $error("Enables not cleared by LPC reset.");

  property p_no_arm;
    wr_ctl && i_bus.wdata[6] && !st_r.arm[6] && !st_r.ctl[6] |=> !st_r.ctl[6];
  endproperty
  a_no_arm: assert property (p_no_arm) else $error("IRQ10 enable set without a prior read of zero.");

  property p_read_then_set;
    rd_ctl && !st_r.ctl[3] && !lpc_rst ##1 wr_ctl && i_bus.wdata[3] && !lpc_rst |=> st_r.ctl[3];
  endproperty
  a_read_then_set: assert property (p_read_then_set) else $error("IRQ11 enable not set after read of zero.");

  property p_irq_out;
    (st_r.ist[hsie_pkg::EV_AUTOCLR] && st_r.imask[hsie_pkg::EV_AUTOCLR]) |-> o_irq;
  endproperty
  a_irq_out: assert property (p_irq_out) else $error("Unmasked status bit without interrupt.");

  // Flag mode gating of each request on its own channel flag.
  property p_irq9_gate;
    !st_r.dir && !st_r.obf3 |-> !o_irq9_req;
  endproperty
  a_irq9_gate: assert property (p_irq9_gate) else $error("IRQ9 request without flag in flag mode.");

  property p_irq6_gate;
    !st_r.dir && !st_r.obf3 |-> !o_irq6_req;
  endproperty
  a_irq6_gate: assert property (p_irq6_gate) else $error("IRQ6 request without flag in flag mode.");

  property p_irq6_flag;
    !st_r.dir && st_r.ctl[4] && st_r.obf3 |-> o_irq6_req;
  endproperty
  a_irq6_flag: assert property (p_irq6_flag) else $error("IRQ6 request missing with enable and flag.");

  property p_irq11_gate;
    !st_r.dir && !st_r.ch2_output_full_flag |-> !o_irq11_req;
  endproperty
  a_irq11_gate: assert property (p_irq11_gate) else $error("IRQ11 request without flag in flag mode.");

  // Direct mode: each request follows its own enable bit alone.
  property p_direct10;
    st_r.dir |-> (o_irq10_req == st_r.ctl[6]);
  endproperty
  a_direct10: assert property (p_direct10) else $error("Direct IRQ10 request differs from its enable.");

  property p_direct9;
    st_r.dir |-> (o_irq9_req == st_r.ctl[5]);
  endproperty
  a_direct9: assert property (p_direct9) else $error("Direct IRQ9 request differs from its enable.");

  property p_direct6;
    st_r.dir |-> (o_irq6_req == st_r.ctl[4]);
  endproperty
  a_direct6: assert property (p_direct6) else $error("Direct IRQ6 request differs from its enable.");

  property p_direct11;
    st_r.dir |-> (o_irq11_req == st_r.ctl[3]);
  endproperty
  a_direct11: assert property (p_direct11) else $error("Direct IRQ11 request differs from its enable.");

  // Slave writes: a zero always clears, a one needs the bit armed by a read of zero.
  property p_write0_10;
    wr_ctl && !i_bus.wdata[6] |=> !st_r.ctl[6];
  endproperty
  a_write0_10: assert property (p_write0_10) else $error("IRQ10 enable survived a write of zero.");

  property p_write0_6;
    wr_ctl && !i_bus.wdata[4] |=> !st_r.ctl[4];
  endproperty
  a_write0_6: assert property (p_write0_6) else $error("IRQ6 enable survived a write of zero.");

  property p_write0_11;
    wr_ctl && !i_bus.wdata[3] |=> !st_r.ctl[3];
  endproperty
  a_write0_11: assert property (p_write0_11) else $error("IRQ11 enable survived a write of zero.");

  property p_no_arm9;
    wr_ctl && i_bus.wdata[5] && !st_r.arm[5] && !st_r.ctl[5] |=> !st_r.ctl[5];
  endproperty
  a_no_arm9: assert property (p_no_arm9) else $error("IRQ9 enable set without a prior read of zero.");

  property p_no_arm6;
    wr_ctl && i_bus.wdata[4] && !st_r.arm[4] && !st_r.ctl[4] |=> !st_r.ctl[4];
  endproperty
  a_no_arm6: assert property (p_no_arm6) else $error("IRQ6 enable set without a prior read of zero.");

  property p_no_arm11;
    wr_ctl && i_bus.wdata[3] && !st_r.arm[3] && !st_r.ctl[3] |=> !st_r.ctl[3];
  endproperty
  a_no_arm11: assert property (p_no_arm11) else $error("IRQ11 enable set without a prior read of zero.");

  property p_arm_set10;
    wr_ctl && i_bus.wdata[6] && st_r.arm[6] && !lpc_rst |=> st_r.ctl[6];
  endproperty
  a_arm_set10: assert property (p_arm_set10) else $error("Armed IRQ10 enable not set by a write of one.");

  property p_arm_set9;
    wr_ctl && i_bus.wdata[5] && st_r.arm[5] && !lpc_rst |=> st_r.ctl[5];
  endproperty
  a_arm_set9: assert property (p_arm_set9) else $error("Armed IRQ9 enable not set by a write of one.");

  property p_arm_set6;
    wr_ctl && i_bus.wdata[4] && st_r.arm[4] && !lpc_rst |=> st_r.ctl[4];
  endproperty
  a_arm_set6: assert property (p_arm_set6) else $error("Armed IRQ6 enable not set by a write of one.");

  property p_lpc_disarm;
    lpc_rst |=> (st_r.arm == 8'h00);
  endproperty
  a_lpc_disarm: assert property (p_lpc_disarm) else $error("Enables still armed after LPC reset.");

  // Enables move only on a write, an LPC reset or a flag clear in flag mode.
  property p_ctl_hold;
    !wr_ctl && !lpc_rst && (hw_clr == 8'h00) |=> $stable(st_r.ctl);
  endproperty
  a_ctl_hold: assert property (p_ctl_hold) else $error("Enables changed with no cause.");

  property p_dir_keep;
    st_r.dir && !wr_ctl && !lpc_rst |=> $stable(st_r.ctl);
  endproperty
  a_dir_keep: assert property (p_dir_keep) else $error("Enables changed in direct mode with no cause.");

  property p_impl;
    (st_r.ctl & ~hsie_pkg::CTL_IMPL) == 8'h00;
  endproperty
  a_impl: assert property (p_impl) else $error("Unimplemented enable bit set.");

  property p_lpc_sync;
    !i_lreset_n |-> ##2 lpc_rst;
  endproperty
  a_lpc_sync: assert property (p_lpc_sync) else $error("LPC hardware reset not seen after two cycles.");

  property p_mode_write;
    i_bus.wr && (i_bus.addr == hsie_pkg::OFS_MODE) |=> (st_r.dir == $past(i_bus.wdata[hsie_pkg::MODE_DIR_BIT]));
  endproperty
  a_mode_write: assert property (p_mode_write) else $error("Direct mode selector not written.");

  property p_autoclr_ev;
    !st_r.dir && st_r.ch2_output_full_flag && !i_ch2_obf && st_r.ctl[3] && !wr_ctl && !lpc_rst |=> st_r.ist[hsie_pkg::EV_AUTOCLR];
  endproperty
  a_autoclr_ev: assert property (p_autoclr_ev) else $error("Auto clear event not recorded.");

  // Register read data and sticky interrupt status.
  property p_rdata_idle;
    !i_bus.rd |=> (o_rdata == 8'h00);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("Read data not zero outside a read answer.");

  property p_rdata_ctl;
    rd_ctl |=> (o_rdata == $past(st_r.ctl));
  endproperty
  a_rdata_ctl: assert property (p_rdata_ctl) else $error("Enable register read back wrong.");

  property p_irq_low;
    ((st_r.ist & st_r.imask) == 5'h00) |-> !o_irq;
  endproperty
  a_irq_low: assert property (p_irq_low) else $error("Interrupt with no unmasked status bit.");

  property p_ist_sticky;
    st_r.ist[3] && !w1c[3] |=> st_r.ist[3];
  endproperty
  a_ist_sticky: assert property (p_ist_sticky) else $error("Status bit lost without a clear.");

  property p_rise10;
    !o_irq10_req ##1 o_irq10_req |-> st_r.ist[3];
  endproperty
  a_rise10: assert property (p_rise10) else $error("IRQ10 request rise not recorded.");

  property p_rise11;
    !o_irq11_req ##1 o_irq11_req |-> st_r.ist[0];
  endproperty
  a_rise11: assert property (p_rise11) else $error("IRQ11 request rise not recorded.");

  // Main scenarios.
  c_flag_irq10: cover property (!st_r.dir && st_r.obf3 && st_r.ctl[6] ##1 o_irq10_req);
  c_direct_irq11: cover property (st_r.dir ##1 o_irq11_req && !st_r.ch2_output_full_flag);
  c_autoclear: cover property (st_r.ctl[5] ##1 !st_r.ctl[5] && st_r.ist[hsie_pkg::EV_AUTOCLR]);
  c_lpc_rst: cover property (st_r.ctl[4] && lpc_rst ##1 st_r.ctl == 8'h00);
  c_back_to_back: cover property (rd_ctl ##1 wr_ctl);

endmodule : hsie_core

// [verif/hsie_host_model.sv]
// Host side model: free running link clock and the LPC hardware and software resets.
`timescale 1ns/100ps
module hsie_host_model (
  input  wire logic i_hw_rst,
  input  wire logic i_sw_rst,
  output logic      o_lclk,
  output logic      o_lreset_n,
  output logic      o_lsrst
);
  // The 80 ns link clock starts off phase with the system clock.
  initial begin
    o_lclk = 1'b0;
    #3;
    forever #40 o_lclk = ~o_lclk;
  end
  // Reset lines follow the commands of the bench.
  assign o_lreset_n = ~i_hw_rst;
  assign o_lsrst    = i_sw_rst;
endmodule : hsie_host_model

// [verif/tb.sv]
// Self-checking bench for the serial IRQ enable block.
`timescale 1ns/100ps
module tb;
  typedef struct packed {
    logic [7:0] m;
    logic       c;
    logic [3:0] q;
  } hsie_row_t;
  logic                i_mclk, i_nrst, ch3, ch2, hw, sw, lclk, lrn, lsr, irq;
  hsie_pkg::hsie_bus_t bus;
  logic [7:0]          rdata;
  logic [3:0]          req;
  int                  mismatches, checked;
  hsie_row_t           rows [4];

  hsie_core u_hsie_core (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_bus(bus), .o_rdata(rdata),
    .i_ch3_obf(ch3), .i_ch2_obf(ch2), .i_lclk(lclk), .i_lreset_n(lrn), .i_lsrst(lsr),
    .o_irq10_req(req[3]), .o_irq9_req(req[2]), .o_irq6_req(req[1]), .o_irq11_req(req[0]), .o_irq(irq));
  hsie_host_model u_hsie_host_model (.i_hw_rst(hw), .i_sw_rst(sw), .o_lclk(lclk), .o_lreset_n(lrn),
    .o_lsrst(lsr));

  // Compares one value and counts the result.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Waits whole cycles and steps past the edge so outputs have settled.
  task automatic wt(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask : wt
  // One cycle register write.
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_mclk);
    bus.wr <= 1'b0;
  endtask : wr
  // One cycle register read; data are looked at in the following cycle only.
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge i_mclk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge i_mclk);
    bus.rd <= 1'b0;
    #1;
    chk(rdata, e);
  endtask : rd
  // Sets all enables, holds an LPC reset of either kind and expects them cleared.
  task automatic lpc(input logic s);
    rd(hsie_pkg::OFS_CTL, 8'h00);
    wr(hsie_pkg::OFS_CTL, 8'h78);
    @(posedge i_mclk);
    if (s) sw <= 1'b1;
    else hw <= 1'b1;
    wt(24);
    chk({4'h0, req}, 8'h00);
    rd(hsie_pkg::OFS_STAT, 8'h40);
    @(posedge i_mclk);
    sw <= 1'b0;
    hw <= 1'b0;
    wt(16);
    rd(hsie_pkg::OFS_CTL, 8'h00);
    rd(hsie_pkg::OFS_STAT, 8'h00);
    wr(hsie_pkg::OFS_CTL, 8'h08);
    rd(hsie_pkg::OFS_CTL, 8'h08);
    wr(hsie_pkg::OFS_CTL, 8'h00);
    $display("test lpc reset %0d done", s);
  endtask : lpc
  // Prints the counts and the verdict, then ends the run.
  task automatic complete_run;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run

  // System clock at 100 MHz.
  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end

  // Main sequence: table of enables, then the awkward cases.
  initial begin
    i_nrst = 1'b0;
    bus = '0;
    ch3 = 1'b0;
    ch2 = 1'b0;
    hw = 1'b0;
    sw = 1'b0;
    mismatches = 0;
    checked = 0;
    rows = '{'{8'h40, 1'b0, 4'h8}, '{8'h20, 1'b0, 4'h4}, '{8'h10, 1'b0, 4'h2}, '{8'h08, 1'b1, 4'h1}};
    repeat (4) @(posedge i_mclk);
    i_nrst <= 1'b1;
    wt(1);
    chk({3'h0, irq, req}, 8'h00);
    wt(5);
    rd(hsie_pkg::OFS_CTL, 8'h00);
    $display("test reset done");
    wr(hsie_pkg::OFS_IMASK, 8'h1F);
    foreach (rows[i]) begin
      rd(hsie_pkg::OFS_CTL, 8'h00);
      wr(hsie_pkg::OFS_CTL, rows[i].m);
      rd(hsie_pkg::OFS_CTL, rows[i].m);
      @(posedge i_mclk);
      if (rows[i].c) ch2 <= 1'b1;
      else ch3 <= 1'b1;
      wt(2);
      chk({4'h0, req}, {4'h0, rows[i].q});
      rd(hsie_pkg::OFS_STAT, {2'b00, rows[i].c, ~rows[i].c, rows[i].q});
      @(posedge i_mclk);
      ch2 <= 1'b0;
      ch3 <= 1'b0;
      wt(2);
      chk({4'h0, req}, 8'h00);
      rd(hsie_pkg::OFS_CTL, 8'h00);
      $display("test row %0d done", i);
    end
    // Every request rose and every enable was auto-cleared.
    rd(hsie_pkg::OFS_IST, 8'h1F);
    chk({7'h0, irq}, 8'h01);
    wr(hsie_pkg::OFS_IMASK, 8'h00);
    wt(1);
    chk({7'h0, irq}, 8'h00);
    wr(hsie_pkg::OFS_IMASK, 8'h1F);
    wr(hsie_pkg::OFS_IST, 8'h1F);
    wt(1);
    chk({7'h0, irq}, 8'h00);
    $display("test interrupt done");
    // A write of 1 without a read of 0 since the last write is ignored.
    wr(hsie_pkg::OFS_CTL, 8'h00);
    wr(hsie_pkg::OFS_CTL, 8'h78);
    rd(hsie_pkg::OFS_CTL, 8'h00);
    rd(4'hF, 8'h00);
    $display("test unarmed done");
    // Back to back read and write with no idle cycle between the strobes.
    @(posedge i_mclk);
    bus <= '{addr: hsie_pkg::OFS_CTL, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge i_mclk);
    bus <= '{addr: hsie_pkg::OFS_CTL, wdata: 8'h08, wr: 1'b1, rd: 1'b0};
    #1;
    chk(rdata, 8'h00);
    @(posedge i_mclk);
    bus.wr <= 1'b0;
    rd(hsie_pkg::OFS_CTL, 8'h08);
    wr(hsie_pkg::OFS_CTL, 8'h00);
    $display("test back to back done");
    // Direct mode raises every request with both flags low.
    wr(hsie_pkg::OFS_MODE, 8'h01);
    rd(hsie_pkg::OFS_MODE, 8'h01);
    rd(hsie_pkg::OFS_CTL, 8'h00);
    wr(hsie_pkg::OFS_CTL, 8'h78);
    wt(1);
    chk({4'h0, req}, 8'h0F);
    // In direct mode a flag pulse neither clears the enables nor drops the requests.
    @(posedge i_mclk);
    ch3 <= 1'b1;
    ch2 <= 1'b1;
    @(posedge i_mclk);
    ch3 <= 1'b0;
    ch2 <= 1'b0;
    wt(2);
    chk({4'h0, req}, 8'h0F);
    rd(hsie_pkg::OFS_CTL, 8'h78);
    wr(hsie_pkg::OFS_CTL, 8'h00);
    wt(1);
    chk({4'h0, req}, 8'h00);
    $display("test direct done");
    lpc(1'b0);
    lpc(1'b1);
    // Mid-run system reset clears the enables, the mode and the status.
    rd(hsie_pkg::OFS_CTL, 8'h00);
    wr(hsie_pkg::OFS_CTL, 8'h78);
    @(posedge i_mclk);
    i_nrst <= 1'b0;
    wt(4);
    chk({3'h0, irq, req}, 8'h00);
    @(posedge i_mclk);
    i_nrst <= 1'b1;
    wt(1);
    chk({3'h0, irq, req}, 8'h00);
    wt(5);
    rd(hsie_pkg::OFS_CTL, 8'h00);
    rd(hsie_pkg::OFS_MODE, 8'h00);
    rd(hsie_pkg::OFS_IST, 8'h00);
    $display("test mid-run reset done");
    complete_run();
  end
endmodule : tb
